// >>> design/scan_pkg.sv
// shared constants for the linear array scan sequencer and its controller
package scan_pkg;
    localparam int PIXELS_SECTION   = 384;      // one section read alone
    localparam int PIXELS_CASCADE   = 768;      // both sections in series
    localparam int SETUP_CLOCKS     = 18;       // clocks spent resetting the integrators
    localparam int PIXEL_WIDTH      = 12;       // width of a digitised pixel level
    localparam int CLK_MHZ          = 25;       // system clock rate
    localparam int ARRAY_CLK_MAX_MHZ = 8;       // fastest legal array clock
    localparam int TQT_NS           = 20000;    // charge transfer wait, ns
    localparam int TQT_CYCLES       = (TQT_NS * CLK_MHZ + 999) / 1000;
    localparam int MAX_PERIOD_MS    = 100;      // longest start to start interval
    localparam int MAX_PERIOD_CYCLES = MAX_PERIOD_MS * CLK_MHZ * 1000;
    localparam int MIN_HALF_CYCLES  = (CLK_MHZ + 2 * ARRAY_CLK_MAX_MHZ - 1)
                                      / (2 * ARRAY_CLK_MAX_MHZ);
    localparam int HALF_CYCLES      = 4;        // default array clock half period
    localparam int PERIOD_WIDTH     = 22;       // wide enough for the 100 ms count
endpackage : scan_pkg

// >>> design/scan_link_if.sv
// link between the array end and the controller end
`timescale 1ns/1ps
interface scan_link_if #(
    parameter int W = scan_pkg::PIXEL_WIDTH
);
    logic         arrayClk;        // array clock, made by the controller
    logic         startPulse;      // scan start and hold strobe, one signal
    logic [W-1:0] pixelVoltageOut; // digitised stand-in for the analog output
    logic         pixelOutEn;      // high while the output is driven

    modport sensor (
        input  arrayClk,
        input  startPulse,
        output pixelVoltageOut,
        output pixelOutEn
    );
    modport controller (
        output arrayClk,
        output startPulse,
        input  pixelVoltageOut,
        input  pixelOutEn
    );
endinterface : scan_link_if

// >>> design/pin_sync.sv
// three stage pin synchroniser, level accepted once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk,      // system clock
    input  wire logic nrst,     // async reset, active low
    input  wire logic pinIn,    // raw pin level
    output logic      levelOut  // filtered level
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       level_reg;
    logic       level_next;

    // stage 0 feeds only stage 1; the filter looks at stages 1 and 2
    always_comb begin
        stage_next = {stage_reg[1:0], pinIn};
        level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage_reg <= 3'h0;
            level_reg <= 1'h0;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign levelOut = level_reg;
endmodule : pin_sync

// >>> design/scan_sensor_end.sv
// array end: global hold, integrator reset window and one pixel per clock
`timescale 1ns/1ps
module scan_sensor_end #(
    parameter int N = scan_pkg::PIXELS_CASCADE,  // pixel count
    parameter int W = scan_pkg::PIXEL_WIDTH      // pixel level width
) (
    input  wire logic                 clk,                   // system clock
    input  wire logic                 nrst,                  // async reset, active low
    scan_link_if.sensor               link,                  // link to the controller
    input  wire logic [N-1:0][W-1:0]  lightIn,               // light per pixel per clock
    output logic                      integratorResetSwitch, // high: integrators zeroed
    output logic [N-1:0]              sampleSelectSwitch     // high: pixel tracks integrator
);
    localparam int CW = $clog2(N + 1);
    localparam logic [CW-1:0] SETUP = CW'(scan_pkg::SETUP_CLOCKS);
    localparam logic [CW-1:0] LAST  = CW'(N);

    logic clkLvl;
    logic startLvl;
    logic clkPrev_reg, clkPrev_next;
    logic active_reg, active_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [W-1:0]  out_reg, out_next;
    logic          outEn_reg, outEn_next;
    logic [N-1:0][W-1:0] integ_reg, integ_next;
    logic [N-1:0][W-1:0] sample_reg, sample_next;
    logic clkRise;

    pin_sync clkSync   (.clk(clk), .nrst(nrst), .pinIn(link.arrayClk),   .levelOut(clkLvl));
    pin_sync startSync (.clk(clk), .nrst(nrst), .pinIn(link.startPulse), .levelOut(startLvl));

    assign clkRise = clkLvl & ~clkPrev_reg;

    // sequencing on each array clock rising edge; start wins over the running scan
    always_comb begin
        clkPrev_next = clkLvl;
        active_next  = active_reg;
        cnt_next     = cnt_reg;
        out_next     = out_reg;
        outEn_next   = outEn_reg;
        if (clkRise && startLvl) begin
            active_next = 1'h1;
            cnt_next    = '0;
            out_next    = sample_reg[0];
            outEn_next  = 1'h1;
        end else if (clkRise && active_reg) begin
            cnt_next = cnt_reg + 1'h1;
            if (cnt_next == LAST) begin
                active_next = 1'h0;
                outEn_next  = 1'h0;
            end else begin
                out_next = sample_reg[cnt_next];
            end
        end
    end

    // integrators are zeroed for the start clock and 17 more, freed on the 19th
    assign integratorResetSwitch = active_reg && (cnt_reg < SETUP);

    // per pixel: hold from start until after its own output and past setup
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : pixelGen
            logic [W:0] sum;
            assign sum = {1'b0, integ_reg[i]} + {1'b0, lightIn[i]};
            assign sampleSelectSwitch[i] = !active_reg ||
                ((cnt_reg >= SETUP) && (cnt_reg > CW'(i)));
            always_comb begin
                if (integratorResetSwitch) begin
                    integ_next[i] = '0;
                end else begin
                    integ_next[i] = sum[W] ? {W{1'b1}} : sum[W-1:0]; // saturate
                end
                // a start edge freezes every sample at once
                if (clkRise && startLvl) begin
                    sample_next[i] = sample_reg[i];
                end else begin
                    sample_next[i] = sampleSelectSwitch[i] ? integ_reg[i] : sample_reg[i];
                end
            end
        end
    endgenerate

    // held samples are shown while the next period integrates
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clkPrev_reg <= 1'h0;
            active_reg  <= 1'h0;
            cnt_reg     <= '0;
            out_reg     <= '0;
            outEn_reg   <= 1'h0;
            integ_reg   <= '0;
            sample_reg  <= '0;
        end else begin
            clkPrev_reg <= clkPrev_next;
            active_reg  <= active_next;
            cnt_reg     <= cnt_next;
            out_reg     <= out_next;
            outEn_reg   <= outEn_next;
            integ_reg   <= integ_next;
            sample_reg  <= sample_next;
        end
    end

    assign link.pixelVoltageOut = out_reg;
    assign link.pixelOutEn      = outEn_reg;
endmodule : scan_sensor_end

// >>> design/scan_controller_end.sv
// controller end: makes the array clock and start strobe, collects pixels
//
// How it works
// - integration is start-to-hold minus eighteen clocks
// - start and hold are one common strobe
// - start pulse at clock edge begins scan
// - at least pixel count plus one clocks
// - extra wait allowed, start interval at most 100 ms
// - start latches all pixels, shows first
// - each clock advances to next pixel
// - integrators held reset start plus 17 clocks
// - nineteenth clock releases all integrators together
// - pixel resumes sampling clock after output, not before the nineteenth
// - clock n+1: last pixel samples, output floats
// - wait 20 us transfer after n+1 clocks
// - integration at least minimum computed period
// - flush first frame after power up
// - park array clock low while idle
// - previous frame shifts out during integration
// - keep period in range, shorten on saturation
// - pixel stands whole clock, sample inside it
// - array clock never above 8 MHz
// - start returns low before next rising edge
`timescale 1ns/1ps
module scan_controller_end #(
    parameter int N          = scan_pkg::PIXELS_CASCADE,  // pixel count
    parameter int W          = scan_pkg::PIXEL_WIDTH,     // pixel level width
    parameter int HALF       = scan_pkg::HALF_CYCLES,     // array clock half period
    parameter int MAX_PERIOD = scan_pkg::MAX_PERIOD_CYCLES, // longest start interval
    parameter int TQT        = scan_pkg::TQT_CYCLES,      // charge transfer wait
    parameter logic [W-1:0] SAT_LEVEL = {W{1'b1}}         // level taken as saturated
) (
    input  wire logic                  clk,          // system clock
    input  wire logic                  nrst,         // async reset, active low
    scan_link_if.controller            link,         // link to the array
    input  wire logic                  runEnable,    // high: scan continuously
    input  wire logic                  periodLoad,   // pulse: take periodIn
    input  wire logic [scan_pkg::PERIOD_WIDTH-1:0] periodIn, // wanted interval, cycles
    output logic [W-1:0]               pixelData,    // captured pixel level
    output logic [$clog2(N)-1:0]       pixelIndex,   // index of pixelData
    output logic                       pixelValid,   // pulse: pixelData is new
    output logic                       frameDone,    // pulse: last pixel captured
    output logic                       flushing,     // high while power-up frame runs
    output logic [scan_pkg::PERIOD_WIDTH-1:0] periodNow // interval in force
);
    localparam int PW = scan_pkg::PERIOD_WIDTH;
    localparam int CW = $clog2(N + 1);
    localparam int HW = $clog2(2 * HALF);
    localparam int TW = $clog2(TQT + 1);
    localparam logic [PW-1:0] MIN_CYC = PW'((N + 1) * 2 * HALF + TQT);
    localparam logic [PW-1:0] MAX_CYC = PW'(MAX_PERIOD);
    localparam logic [HW-1:0] PH_RISE = HW'(HALF);
    localparam logic [HW-1:0] PH_END  = HW'(2 * HALF - 1);
    localparam logic [CW-1:0] LAST    = CW'(N);
    localparam int            IW      = $clog2(N);

    typedef enum {IDLE, START, SHIFT, WAIT} state_type;

    state_type      state_reg, state_next;
    logic [HW-1:0]  phase_reg, phase_next;
    logic [CW-1:0]  edge_reg, edge_next;
    logic [PW-1:0]  periodCnt_reg, periodCnt_next;
    logic [TW-1:0]  tqt_reg, tqt_next;
    logic [PW-1:0]  period_reg, period_next;
    logic           start_reg, start_next;
    logic           aclk_reg, aclk_next;
    logic [W-1:0]   data_reg, data_next;
    logic [$clog2(N)-1:0] index_reg, index_next;
    logic           valid_reg, valid_next;
    logic           done_reg, done_next;
    logic           flush_reg, flush_next;
    logic           sat_reg, sat_next;
    logic [PW-1:0]  target;

    // the fastest clock the array accepts bounds the divider
    initial begin
        if (HALF < scan_pkg::MIN_HALF_CYCLES) begin
            $error("array clock half period too short");
        end
    end

    // interval clamped between the minimum cycle time and 100 ms
    always_comb begin
        if (period_reg < MIN_CYC) begin
            target = MIN_CYC;
        end else if (period_reg > MAX_CYC) begin
            target = MAX_CYC;
        end else begin
            target = period_reg;
        end
    end

    // scan sequencing
    always_comb begin
        state_next     = state_reg;
        phase_next     = phase_reg;
        edge_next      = edge_reg;
        periodCnt_next = (periodCnt_reg == '1) ? periodCnt_reg : periodCnt_reg + 1'h1;
        tqt_next       = tqt_reg;
        period_next    = periodLoad ? periodIn : period_reg;
        start_next     = start_reg;
        aclk_next      = aclk_reg;
        data_next      = data_reg;
        index_next     = index_reg;
        valid_next     = 1'h0;
        done_next      = 1'h0;
        flush_next     = flush_reg;
        sat_next       = sat_reg;
        case (state_reg)
            IDLE: begin
                aclk_next = 1'h0;
                if (runEnable) begin
                    state_next = START;
                    phase_next = '0;
                    start_next = 1'h1;                   // one strobe for start and hold
                end
            end
            START: begin
                // start is set up while the clock is low, then the clock rises on it
                phase_next = phase_reg + 1'h1;
                if (phase_reg == PH_RISE - 1'h1) begin
                    aclk_next      = 1'h1;
                    periodCnt_next = '0;
                    edge_next      = '0;
                    sat_next       = 1'h0;
                    state_next     = SHIFT;
                    phase_next     = PH_RISE;
                end
            end
            SHIFT: begin
                phase_next = (phase_reg == PH_END) ? '0 : phase_reg + 1'h1;
                aclk_next  = (phase_next >= PH_RISE);
                // sample just before the next rise: the array shows a pixel about five
                // cycles after its rise because of its pin filters, so an earlier window
                // would still see the previous pixel; needs HALF of three or more
                if (phase_reg == PH_RISE - 1'h1) begin
                    data_next  = link.pixelVoltageOut;
                    index_next = IW'(edge_reg - 1'h1);   // pixel of the last rise
                    valid_next = !flush_reg;
                    if (link.pixelVoltageOut >= SAT_LEVEL) begin
                        sat_next = 1'h1;
                    end
                end
                if (phase_reg == PH_END) begin
                    start_next = 1'h0;
                    if (edge_reg == LAST) begin
                        // n+1 edges given; clock parks low for the transfer wait
                        aclk_next  = 1'h0;
                        state_next = WAIT;
                        tqt_next   = '0;
                        done_next  = !flush_reg;
                        flush_next = 1'h0;
                        if (sat_reg) begin
                            period_next = period_reg >> 1;
                        end
                    end else begin
                        edge_next = edge_reg + 1'h1;
                    end
                end
            end
            WAIT: begin
                aclk_next = 1'h0;
                if (tqt_reg != TW'(TQT)) begin
                    tqt_next = tqt_reg + 1'h1;
                end
                // next start only after the transfer and the chosen interval; the extra
                // one keeps start-to-start equal to target above the minimum and one over it at the minimum, so 100 ms is never passed
                if (tqt_reg == TW'(TQT) && periodCnt_reg + PW'(HALF + 1) >= target) begin
                    state_next = runEnable ? START : IDLE;
                    phase_next = '0;
                    start_next = runEnable;
                end
            end
            default: begin
                state_next = IDLE;
                aclk_next  = 1'h0;
                start_next = 1'h0;
            end
        endcase
    end

    // one register stage for all sequencing state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= IDLE;
            phase_reg     <= '0;
            edge_reg      <= '0;
            periodCnt_reg <= '0;
            tqt_reg       <= '0;
            period_reg    <= '0;
            start_reg     <= 1'h0;
            aclk_reg      <= 1'h0;
            data_reg      <= '0;
            index_reg     <= '0;
            valid_reg     <= 1'h0;
            done_reg      <= 1'h0;
            flush_reg     <= 1'h1;
            sat_reg       <= 1'h0;
        end else begin
            state_reg     <= state_next;
            phase_reg     <= phase_next;
            edge_reg      <= edge_next;
            periodCnt_reg <= periodCnt_next;
            tqt_reg       <= tqt_next;
            period_reg    <= period_next;
            start_reg     <= start_next;
            aclk_reg      <= aclk_next;
            data_reg      <= data_next;
            index_reg     <= index_next;
            valid_reg     <= valid_next;
            done_reg      <= done_next;
            flush_reg     <= flush_next;
            sat_reg       <= sat_next;
        end
    end

    assign link.arrayClk   = aclk_reg;
    assign link.startPulse = start_reg;
    assign pixelData       = data_reg;
    assign pixelIndex      = index_reg;
    assign pixelValid      = valid_reg;
    assign frameDone       = done_reg;
    assign flushing        = flush_reg;
    assign periodNow       = target;
endmodule : scan_controller_end

// >>> dv/scan_link_sva.sv
// concurrent checks on the link between the array end and the controller end
`timescale 1ns/1ps
module scan_link_sva #(
    parameter int N          = 768,     // pixel count
    parameter int W          = 12,      // pixel level width
    parameter int HALF       = 4,       // array clock half period
    parameter int TQT        = 500,     // charge transfer wait, cycles
    parameter int MAX_PERIOD = 2500000  // longest start interval, cycles
) (
    input wire logic         clk,             // system clock
    input wire logic         nrst,            // async reset, active low
    input wire logic         arrayClk,        // array clock
    input wire logic         startPulse,      // start and hold strobe
    input wire logic [W-1:0] pixelVoltageOut, // pixel level
    input wire logic         pixelOutEn       // high while output driven
);
    logic        startD;
    logic        clkD;
    logic        seenStart;
    logic [15:0] edgeCnt;
    logic [31:0] gapCnt;
    logic [31:0] lowCnt;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // edges per frame, start spacing and low time; the first start after reset has no gap
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            startD    <= 1'b0;
            clkD      <= 1'b0;
            seenStart <= 1'b0;
            edgeCnt   <= '0;
            gapCnt    <= '0;
            lowCnt    <= '0;
        end else begin
            startD <= startPulse;
            clkD   <= arrayClk;
            lowCnt <= arrayClk ? 32'h0 : lowCnt + 32'h1;
            if (startPulse && !startD) begin
                seenStart <= 1'b1;
                gapCnt    <= 32'h1;
                edgeCnt   <= '0;
            end else begin
                gapCnt <= gapCnt + 32'h1;
                if (arrayClk && !clkD) edgeCnt <= edgeCnt + 16'h1;
            end
        end
    end

    chk_start_lead: assert property ($rose(startPulse) |-> !arrayClk [*4] ##1 arrayClk)
        else $error("array clock did not rise four cycles after start");
    chk_start_drop: assert property ($fell(startPulse) |-> !arrayClk ##4 $rose(arrayClk))
        else $error("start not dropped just before the next rise");
    chk_clk_width: assert property ($rose(arrayClk) |-> arrayClk [*4] ##1 !arrayClk)
        else $error("array clock high phase not four cycles");
    chk_out_on_start: assert property ($rose(startPulse) |-> !pixelOutEn ##[5:10] $rose(pixelOutEn))
        else $error("output not driven after start");
    chk_pixel_stands: assert property ($changed(pixelVoltageOut) && pixelOutEn |=> $stable(pixelVoltageOut) [*6])
        else $error("pixel level changed inside its period");
    chk_float_count: assert property ($fell(pixelOutEn) |-> edgeCnt == 16'(N + 1))
        else $error("output floated after wrong number of edges");
    chk_idle_clk_low: assert property (edgeCnt == 16'(N + 1) && !startPulse |-> !$rose(arrayClk))
        else $error("array clock ran while idle");
    chk_start_spacing: assert property ($rose(startPulse) && seenStart |-> gapCnt >= 32'((N + 1) * 2 * HALF + TQT) && gapCnt <= 32'(MAX_PERIOD))
        else $error("start interval out of range");
    chk_transfer_wait: assert property ($rose(startPulse) && seenStart |-> lowCnt >= 32'(TQT))
        else $error("charge transfer wait too short");
endmodule : scan_link_sva

// >>> dv/linear_array_scan_sequencer_tb_top.sv
// testbench: both ends joined, plus a second array end driven by hand
`timescale 1ns/1ps
module linear_array_scan_sequencer_tb_top;
    localparam int N = 24, W = 12, HALF = 4, TQT = 20, MAXP = 20000;
    localparam int IW = $clog2(N);
    localparam int MINP = (N + 1) * 2 * HALF + TQT;
    logic                              clk, nrst, runEnable, periodLoad;
    logic [scan_pkg::PERIOD_WIDTH-1:0] periodIn, periodNow;
    logic [N-1:0][W-1:0]               lightIn;
    logic [W-1:0]                      pixelData;
    logic [IW-1:0]                     pixelIndex;
    logic                              pixelValid, frameDone, flushing, rstB;
    logic [N-1:0]                      selB;
    int                                errTotal, checked, gapCnt, lastGap, flushHits;
    logic                              startD;

    scan_link_if #(.W(W)) link ();
    scan_link_if #(.W(W)) linkB ();
    scan_sensor_end #(.N(N), .W(W)) u_scan_sensor_end (.clk(clk), .nrst(nrst), .link(link),
        .lightIn(lightIn), .integratorResetSwitch(), .sampleSelectSwitch());
    scan_sensor_end #(.N(N), .W(W)) u_scan_sensor_end_b (.clk(clk), .nrst(nrst), .link(linkB),
        .lightIn(lightIn), .integratorResetSwitch(rstB), .sampleSelectSwitch(selB));
    scan_controller_end #(.N(N), .W(W), .HALF(HALF), .MAX_PERIOD(MAXP), .TQT(TQT))
        u_scan_controller_end (.clk(clk), .nrst(nrst), .link(link), .runEnable(runEnable),
        .periodLoad(periodLoad), .periodIn(periodIn), .pixelData(pixelData),
        .pixelIndex(pixelIndex), .pixelValid(pixelValid), .frameDone(frameDone),
        .flushing(flushing), .periodNow(periodNow));
    scan_link_sva #(.N(N), .W(W), .HALF(HALF), .TQT(TQT), .MAX_PERIOD(MAXP)) u_scan_link_sva (
        .clk(clk), .nrst(nrst), .arrayClk(link.arrayClk), .startPulse(link.startPulse),
        .pixelVoltageOut(link.pixelVoltageOut), .pixelOutEn(link.pixelOutEn));

    always #20 clk = ~clk;

    // start-to-start interval and user pulses seen during the power-up frame
    always @(posedge clk) begin
        startD <= link.startPulse;
        gapCnt <= (link.startPulse && !startD) ? 1 : gapCnt + 1;
        if (link.startPulse && !startD) lastGap <= gapCnt;
        if (flushing === 1'b1 && (pixelValid !== 1'b0 || frameDone !== 1'b0)) flushHits++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            errTotal++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic load_period(input int p);
        periodIn = p[scan_pkg::PERIOD_WIDTH-1:0];
        periodLoad = 1'b1;
        tick(1);
        periodLoad = 1'b0;
    endtask : load_period

    // one array clock period on the hand link; start drops before the next rise
    task automatic hand_edge(input logic s);
        linkB.startPulse = s;
        tick(HALF);
        linkB.arrayClk = 1'b1;
        tick(HALF);
        linkB.arrayClk = 1'b0;
        linkB.startPulse = 1'b0;
        tick(2);
    endtask : hand_edge

    // waits for pixel 0, then takes a whole frame at the fixed eight-cycle spacing
    task automatic grab_frame(output logic [W-1:0] base, output int gap);
        int n = 0;
        while (!(pixelValid === 1'b1 && pixelIndex === '0) && n < 25000) begin
            tick(1);
            n++;
        end
        gap = lastGap;
        base = pixelData;
        for (int k = 0; k < N; k++) begin
            check(pixelValid === 1'b1 && pixelIndex === IW'(k), "pixel order");
            check(pixelData === W'((k % 4 + 1) * base), "pixel level ratio");
            if (k < N - 1) tick(2 * HALF);
        end
        tick(HALF);
        check(frameDone === 1'b1, "frame end pulse");
    endtask : grab_frame

    task automatic test_hand_end;
        for (int k = 0; k <= 20; k++) hand_edge(k == 0);
        hand_edge(1'b1); // restart in mid-scan
        check(rstB === 1'b1 && linkB.pixelOutEn === 1'b1 && selB === '0, "restart");
        for (int k = 1; k <= N; k++) begin
            hand_edge(1'b0);
            check(rstB === (k < 18), "integrator reset window");
            check(selB[k - 1] === (k >= 18), "sampling resumes after output");
        end
        check(linkB.pixelOutEn === 1'b0 && selB === '1, "float after last pixel");
        hand_edge(1'b0);
        check(linkB.pixelOutEn === 1'b0, "idle rise ignored");
        $display("test_hand_end done");
    endtask : test_hand_end

    task automatic test_flush;
        int n = 0;
        runEnable = 1'b1;
        load_period(300);
        while (flushing !== 1'b0 && n < 5000) begin
            tick(1);
            n++;
        end
        check(flushing === 1'b0 && flushHits == 0, "power-up frame hidden");
        $display("test_flush done");
    endtask : test_flush

    task automatic test_integration;
        logic [W-1:0] b1, b2;
        int g1, g2;
        grab_frame(b1, g1);
        check(b1 !== '0, "integrated level");
        check(g1 >= periodNow && g1 <= periodNow + 2 * HALF, "start interval");
        load_period(340);
        grab_frame(b2, g2);
        grab_frame(b2, g2);
        check((b2 - b1) === W'(g2 - g1), "integration tracks interval");
        $display("test_integration done");
    endtask : test_integration

    task automatic test_clamp;
        runEnable = 1'b0;
        load_period(0);
        tick(2);
        check(periodNow === 22'(MINP), "minimum interval");
        load_period(32'h3fffff);
        tick(2);
        check(periodNow === 22'(MAXP), "maximum interval");
        $display("test_clamp done");
    endtask : test_clamp

    // saturated pixel halves the interval each frame down to the minimum
    task automatic test_saturation;
        int n;
        lightIn[3] = 12'hfff;
        load_period(1000);
        runEnable = 1'b1;
        for (int f = 0; f < 6; f++) begin
            n = 0;
            do begin
                tick(1);
                n++;
            end while (frameDone !== 1'b1 && n < 25000);
            tick(2);
            check(periodNow inside {22'd1000, 22'd500, 22'd250, 22'(MINP)}, "halving");
        end
        check(periodNow === 22'(MINP), "clamped after halving");
        $display("test_saturation done");
    endtask : test_saturation

    task automatic results;
        $display("checks %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    initial begin
        repeat (90000) @(posedge clk);
        errTotal++;
        $display("wrong value at %0t: run did not finish", $time);
        results();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        runEnable = 1'b0;
        periodLoad = 1'b0;
        periodIn = '0;
        linkB.arrayClk = 1'b0;
        linkB.startPulse = 1'b0;
        for (int k = 0; k < N; k++) lightIn[k] = W'(k % 4 + 1);
        tick(3);
        nrst = 1'b1;
        test_hand_end();
        test_flush();
        test_integration();
        test_clamp();
        test_saturation();
        results();
    end
endmodule : linear_array_scan_sequencer_tb_top
